/* File: shared/mdsr_pkg.sv */
// Purpose: Constants for the motor drive serial register bank.
// Assumes: 10 MHz system clock, 8N1 serial frames at 19200 baud.
// Notes: Command codes, field positions and timing counts live here.
package mdsr_pkg;

  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BAUD_RATE = 19200;
  // Rounded to nearest: 520.8 cycles per bit
  localparam int unsigned BAUD_CYCLES = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int unsigned PULSE_TICK_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PULSE_TICK_CYCLES = PULSE_TICK_NS / CLK_PERIOD_NS;

  // Read command codes
  localparam logic [6:0] RD_SPEED_INPUT = 7'h11;
  localparam logic [6:0] RD_LOAD_CURRENT = 7'h12;
  localparam logic [6:0] RD_PULSE_PERIOD = 7'h14;
  localparam logic [6:0] RD_PULSE_WIDTH = 7'h15;
  localparam logic [6:0] RD_IXR_COMP = 7'h20;
  localparam logic [6:0] RD_CEILING = 7'h21;
  localparam logic [6:0] RD_SCALE_LOW = 7'h22;
  localparam logic [6:0] RD_SCALE_HIGH = 7'h23;
  localparam logic [6:0] RD_STATUS = 7'h30;
  localparam logic [6:0] RD_LOCK = 7'h31;
  localparam logic [6:0] RD_SAVE_ONE = 7'h32;
  // Write command codes
  localparam logic [6:0] WR_IXR_COMP = 7'h60;
  localparam logic [6:0] WR_CEILING = 7'h61;
  localparam logic [6:0] WR_SCALE_LOW = 7'h62;
  localparam logic [6:0] WR_SCALE_HIGH = 7'h63;
  localparam logic [6:0] WR_LOCK = 7'h71;
  localparam logic [6:0] WR_SAVE_ONE = 7'h72;

  // Frame layout
  localparam logic [7:0] ADDR_FLAG = 8'h80;
  localparam logic [6:0] DATA7_MASK = 7'h7F;
  localparam int unsigned REPLY_BYTES = 5;

  // Status bit positions
  localparam int unsigned ST_REVERSE = 10;
  localparam int unsigned ST_FORWARD = 9;
  localparam int unsigned ST_BRAKE_PIN = 8;
  localparam int unsigned ST_DRIVE_BRAKE = 4;
  localparam int unsigned ST_OVER_TEMP = 2;
  localparam int unsigned ST_OVER_VOLT = 1;
  localparam int unsigned ST_UNDER_VOLT = 0;

  // Lock mask bit positions
  localparam int unsigned LK_ACCEL = 3;
  localparam int unsigned LK_REGEN = 2;
  localparam int unsigned LK_CURRENT = 1;
  localparam int unsigned LK_SPEED = 0;

  // Save mask: defined bits only (1 and 10 are undefined)
  localparam logic [13:0] SAVE_ONE_DEFINED = 14'h3BFD;
  localparam int unsigned SV_ACCEL = 4;
  localparam int unsigned SV_REGEN = 3;
  localparam int unsigned SV_CURRENT = 2;
  localparam int unsigned SV_SPEED = 0;

  // Reset values
  localparam logic [3:0] LOCK_RESET = 4'h0;
  localparam logic [13:0] SAVE_ONE_RESET = 14'h0000;
  localparam logic [13:0] IXR_RESET = 14'h0000;
  localparam logic [11:0] CEILING_RESET = 12'hFFF;
  localparam logic [11:0] SCALE_LOW_RESET = 12'h000;
  localparam logic [11:0] SCALE_HIGH_RESET = 12'hFFF;

endpackage

/* File: logic/mdsr_regbank.sv */
// Purpose: Serial register bank of a brushed DC motor drive controller.
// Assumes: All inputs synchronous to CLK_SYS; host speaks 8N1 at 19200 baud.
// Notes: Read replies echo the frame layout; read requests during a reply are dropped, writes still land.
`timescale 1ns/1ps

// Notes on behaviour
// - Read code 0x11 returns the 12-bit speed input conversion.
// - Read code 0x12 returns the 12-bit present load current.
// - Period of the pulse/brake input is measured, 14 bits, read code 0x14.
// - Pulse width on the pulse/brake input is captured, 14 bits, code 0x15.
// - Compensation written 0x60, read 0x20; times current, added to output.
// - Ceiling written 0x61, read 0x21; caps the demand before the compensation is added.
// - Supply compensation from ceiling only while its enable bit is set.
// - A ceiling of zero or near zero may give zero output voltage.
// - Scale low/high written 0x62/0x63, read 0x22/0x23; map 0% and 100%.
// - Status read 0x30: reverse in bit 10, forward in bit 9.
// - Status bit 8 shows brake pin level, valid outside pulse input mode.
// - Status bit 4 is 0 in drive, 1 in braking.
// - Status bit 1 set while supply exceeds the high shutdown threshold.
// - Status bit 0 set while supply below turn-on threshold; bit 2 over-temperature.
// - Lock mask written 0x71, read 0x31; locked values ignore potentiometers.
// - Lock bits: 3 acceleration, 2 regenerative, 1 current, 0 speed.
// - With speed lock clear the speed input is the voltage demand.
// - The whole lock mask clears on every restart.
// - Save mask written 0x72, read 0x32; writing only marks values.
// - Values saved to flash reload at restart and act as locked.
// - Save mask bits 13..0 select configuration, address, thresholds, limits, speed.
// - Frame: address with top bit, command, two 7-bit data bytes, 7-bit sum.
// - Compensation enable is bit 8 of the second configuration register.
module mdsr_regbank
  import mdsr_pkg::*;
#(
  parameter int unsigned PULSE_TICK_DIV = PULSE_TICK_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic UART_RXD,
  output logic UART_TXD,
  input wire logic [6:0] UNIT_ADDR,
  input wire logic [11:0] SPEED_ADC,
  input wire logic [11:0] LOAD_CURRENT,
  input wire logic [11:0] SERIAL_SPEED,
  input wire logic [11:0] SUPPLY_VOLTAGE,
  input wire logic [11:0] TURN_ON_MIN,
  input wire logic [11:0] TURN_OFF_MAX,
  input wire logic PWM_BRAKE_IN,
  input wire logic PWM_INPUT_MODE,
  input wire logic REVERSE_ACTIVE,
  input wire logic FORWARD_ACTIVE,
  input wire logic BRAKING,
  input wire logic OVER_TEMPERATURE,
  input wire logic [15:0] CONFIG_TWO,
  input wire logic [13:0] FLASH_SAVED_MASK,
  output logic [11:0] OUTPUT_VOLTAGE,
  output logic [3:0] EFFECTIVE_LOCK,
  output logic [13:0] SAVE_SELECT,
  output logic [11:0] SCALE_LOW,
  output logic [11:0] SCALE_HIGH
);

  // The tick divider counter is 16 bits wide
  if (PULSE_TICK_DIV < 1 || PULSE_TICK_DIV > 65535) begin : g_tick_div_check
    $error("PULSE_TICK_DIV out of range");
  end

  typedef enum {MDSR_RX_IDLE, MDSR_RX_START, MDSR_RX_DATA, MDSR_RX_STOP} mdsr_rx_t;
  typedef enum {MDSR_P_ADDR, MDSR_P_CMD, MDSR_P_HI, MDSR_P_LO, MDSR_P_SUM} mdsr_parse_t;
  typedef enum {MDSR_TX_IDLE, MDSR_TX_START, MDSR_TX_DATA, MDSR_TX_STOP} mdsr_tx_t;

  //////////////////////////////////////////////////////////////////////////////
  // Serial receiver

  mdsr_rx_t rx_state_q;
  logic [9:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_shift_q;
  logic rx_valid_q;
  logic [7:0] rx_byte_q;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rx_state_q <= MDSR_RX_IDLE;
      rx_cnt_q <= 10'h000;
      rx_bit_q <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else begin
      rx_valid_q <= 1'b0;
      unique case (rx_state_q)
        MDSR_RX_IDLE: begin
          rx_cnt_q <= 10'h000;
          if (!UART_RXD) begin
            rx_state_q <= MDSR_RX_START;
          end
        end
        MDSR_RX_START: begin
          // Check the start bit at its middle to reject glitches
          if (rx_cnt_q == 10'(BAUD_CYCLES / 2)) begin
            rx_cnt_q <= 10'h000;
            rx_bit_q <= 3'h0;
            rx_state_q <= UART_RXD ? MDSR_RX_IDLE : MDSR_RX_DATA;
          end else begin
            rx_cnt_q <= rx_cnt_q + 10'h001;
          end
        end
        MDSR_RX_DATA: begin
          if (rx_cnt_q == 10'(BAUD_CYCLES - 1)) begin
            rx_cnt_q <= 10'h000;
            rx_shift_q <= {UART_RXD, rx_shift_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_state_q <= MDSR_RX_STOP;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q + 10'h001;
          end
        end
        MDSR_RX_STOP: begin
          if (rx_cnt_q == 10'(BAUD_CYCLES - 1)) begin
            rx_state_q <= MDSR_RX_IDLE;
            // A missing stop bit drops the byte
            if (UART_RXD) begin
              rx_valid_q <= 1'b1;
              rx_byte_q <= rx_shift_q;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q + 10'h001;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame parser

  mdsr_parse_t parse_q;
  logic [6:0] cmd_q;
  logic [6:0] data_hi_q;
  logic [6:0] data_lo_q;
  logic frame_ok_q;
  logic [6:0] sum_calc;

  assign sum_calc = 7'(cmd_q + data_hi_q + data_lo_q) & DATA7_MASK;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      parse_q <= MDSR_P_ADDR;
      cmd_q <= 7'h00;
      data_hi_q <= 7'h00;
      data_lo_q <= 7'h00;
      frame_ok_q <= 1'b0;
    end else begin
      frame_ok_q <= 1'b0;
      if (rx_valid_q) begin
        if (rx_byte_q[7]) begin
          // A flagged byte always restarts framing
          parse_q <= (rx_byte_q[6:0] == UNIT_ADDR) ? MDSR_P_CMD : MDSR_P_ADDR;
        end else begin
          unique case (parse_q)
            MDSR_P_ADDR: parse_q <= MDSR_P_ADDR;
            MDSR_P_CMD: begin
              cmd_q <= rx_byte_q[6:0];
              parse_q <= MDSR_P_HI;
            end
            MDSR_P_HI: begin
              data_hi_q <= rx_byte_q[6:0];
              parse_q <= MDSR_P_LO;
            end
            MDSR_P_LO: begin
              data_lo_q <= rx_byte_q[6:0];
              parse_q <= MDSR_P_SUM;
            end
            MDSR_P_SUM: begin
              frame_ok_q <= (rx_byte_q[6:0] == sum_calc);
              parse_q <= MDSR_P_ADDR;
            end
          endcase
        end
      end
    end
  end

  logic [13:0] wr_value;
  assign wr_value = {data_hi_q, data_lo_q};

  //////////////////////////////////////////////////////////////////////////////
  // Writable registers

  logic [13:0] ixr_q;
  logic [11:0] ceiling_q;
  logic [11:0] scale_low_q;
  logic [11:0] scale_high_q;
  logic [3:0] lock_q;
  logic [13:0] save_one_q;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ixr_q <= IXR_RESET;
      ceiling_q <= CEILING_RESET;
      scale_low_q <= SCALE_LOW_RESET;
      scale_high_q <= SCALE_HIGH_RESET;
      lock_q <= LOCK_RESET;
      save_one_q <= SAVE_ONE_RESET;
    end else if (frame_ok_q) begin
      unique case (cmd_q)
        WR_IXR_COMP: ixr_q <= wr_value;
        WR_CEILING: ceiling_q <= wr_value[11:0];
        WR_SCALE_LOW: scale_low_q <= wr_value[11:0];
        WR_SCALE_HIGH: scale_high_q <= wr_value[11:0];
        WR_LOCK: lock_q <= wr_value[3:0];
        // Marking only; the flash write is triggered elsewhere
        WR_SAVE_ONE: save_one_q <= wr_value & SAVE_ONE_DEFINED;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pulse measurement on the pulse/brake input

  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic pin_prev_q;
  logic [13:0] since_rise_q;
  logic [13:0] high_cnt_q;
  logic [13:0] period_q;
  logic [13:0] width_q;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 16'(PULSE_TICK_DIV - 1));
      tick_cnt_q <= (tick_cnt_q == 16'(PULSE_TICK_DIV - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      // Follow the pin so that a high idle level gives no false edge at release
      pin_prev_q <= PWM_BRAKE_IN;
      since_rise_q <= 14'h0000;
      high_cnt_q <= 14'h0000;
      period_q <= 14'h0000;
      width_q <= 14'h0000;
    end else begin
      pin_prev_q <= PWM_BRAKE_IN;
      if (PWM_BRAKE_IN && !pin_prev_q) begin
        period_q <= since_rise_q;
        since_rise_q <= 14'h0000;
        high_cnt_q <= 14'h0000;
      end else begin
        // Counts saturate so the first edge after a stall captures full scale
        if (tick_q && since_rise_q != 14'h3FFF) begin
          since_rise_q <= since_rise_q + 14'h0001;
        end
        if (tick_q && PWM_BRAKE_IN && high_cnt_q != 14'h3FFF) begin
          high_cnt_q <= high_cnt_q + 14'h0001;
        end
      end
      if (!PWM_BRAKE_IN && pin_prev_q) begin
        width_q <= high_cnt_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status and effective lock

  logic [10:0] status;
  logic [3:0] lock_eff;

  always_comb begin
    status = 11'h000;
    status[ST_REVERSE] = REVERSE_ACTIVE;
    status[ST_FORWARD] = FORWARD_ACTIVE;
    // Pin level is meaningless while the pin carries pulses
    status[ST_BRAKE_PIN] = PWM_BRAKE_IN & ~PWM_INPUT_MODE;
    status[ST_DRIVE_BRAKE] = BRAKING;
    status[ST_OVER_TEMP] = OVER_TEMPERATURE;
    status[ST_OVER_VOLT] = SUPPLY_VOLTAGE > TURN_OFF_MAX;
    status[ST_UNDER_VOLT] = SUPPLY_VOLTAGE < TURN_ON_MIN;
  end

  always_comb begin
    lock_eff = lock_q;
    lock_eff[LK_ACCEL] = lock_q[LK_ACCEL] | FLASH_SAVED_MASK[SV_ACCEL];
    lock_eff[LK_REGEN] = lock_q[LK_REGEN] | FLASH_SAVED_MASK[SV_REGEN];
    lock_eff[LK_CURRENT] = lock_q[LK_CURRENT] | FLASH_SAVED_MASK[SV_CURRENT];
    lock_eff[LK_SPEED] = lock_q[LK_SPEED] | FLASH_SAVED_MASK[SV_SPEED];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output voltage demand

  logic [11:0] demand;
  logic [11:0] capped;
  logic [23:0] ref_prod;
  logic [25:0] ixr_prod;
  logic [12:0] boosted;

  always_comb begin
    // Locked speed frees the input for sensor use
    demand = lock_eff[LK_SPEED] ? SERIAL_SPEED : SPEED_ADC;
    ref_prod = demand * ceiling_q;
    if (CONFIG_TWO[8]) begin
      // Ceiling acts as full-scale reference for the demand
      capped = ref_prod[23:12];
    end else begin
      capped = (demand > ceiling_q) ? ceiling_q : demand;
    end
    ixr_prod = ixr_q * LOAD_CURRENT;
    boosted = {1'b0, capped} + {1'b0, ixr_prod[23:12]};
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      OUTPUT_VOLTAGE <= 12'h000;
      EFFECTIVE_LOCK <= LOCK_RESET;
      SAVE_SELECT <= SAVE_ONE_RESET;
      SCALE_LOW <= SCALE_LOW_RESET;
      SCALE_HIGH <= SCALE_HIGH_RESET;
    end else begin
      // Product bits above the 12-bit window saturate as well
      OUTPUT_VOLTAGE <= (boosted[12] || |ixr_prod[25:24]) ? 12'hFFF : boosted[11:0];
      EFFECTIVE_LOCK <= lock_eff;
      SAVE_SELECT <= save_one_q;
      // Scaling endpoints go to the speed mapper, used after a restart
      SCALE_LOW <= scale_low_q;
      SCALE_HIGH <= scale_high_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux and reply transmitter

  logic [13:0] rd_value;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    rd_value = 14'h0000;
    unique case (cmd_q)
      RD_SPEED_INPUT: rd_value = {2'b00, SPEED_ADC};
      RD_LOAD_CURRENT: rd_value = {2'b00, LOAD_CURRENT};
      RD_PULSE_PERIOD: rd_value = period_q;
      RD_PULSE_WIDTH: rd_value = width_q;
      RD_IXR_COMP: rd_value = ixr_q;
      RD_CEILING: rd_value = {2'b00, ceiling_q};
      RD_SCALE_LOW: rd_value = {2'b00, scale_low_q};
      RD_SCALE_HIGH: rd_value = {2'b00, scale_high_q};
      RD_STATUS: rd_value = {3'b000, status};
      RD_LOCK: rd_value = {10'h000, lock_q};
      RD_SAVE_ONE: rd_value = save_one_q;
      default: rd_hit = 1'b0;
    endcase
  end

  mdsr_tx_t tx_state_q;
  logic [7:0] tx_buf_q [REPLY_BYTES];
  logic [2:0] tx_idx_q;
  logic [9:0] tx_cnt_q;
  logic [2:0] tx_bit_q;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tx_state_q <= MDSR_TX_IDLE;
      tx_idx_q <= 3'h0;
      tx_cnt_q <= 10'h000;
      tx_bit_q <= 3'h0;
      UART_TXD <= 1'b1;
      for (int i = 0; i < REPLY_BYTES; i++) begin
        tx_buf_q[i] <= 8'h00;
      end
    end else begin
      unique case (tx_state_q)
        MDSR_TX_IDLE: begin
          UART_TXD <= 1'b1;
          // Replies use the command frame layout, valid sum included
          if (frame_ok_q && rd_hit) begin
            tx_buf_q[0] <= ADDR_FLAG | {1'b0, UNIT_ADDR};
            tx_buf_q[1] <= {1'b0, cmd_q};
            tx_buf_q[2] <= {1'b0, rd_value[13:7]};
            tx_buf_q[3] <= {1'b0, rd_value[6:0]};
            tx_buf_q[4] <= {1'b0, 7'(cmd_q + rd_value[13:7] + rd_value[6:0]) & DATA7_MASK};
            tx_idx_q <= 3'h0;
            tx_cnt_q <= 10'h000;
            tx_state_q <= MDSR_TX_START;
          end
        end
        MDSR_TX_START: begin
          UART_TXD <= 1'b0;
          if (tx_cnt_q == 10'(BAUD_CYCLES - 1)) begin
            tx_cnt_q <= 10'h000;
            tx_bit_q <= 3'h0;
            tx_state_q <= MDSR_TX_DATA;
          end else begin
            tx_cnt_q <= tx_cnt_q + 10'h001;
          end
        end
        MDSR_TX_DATA: begin
          UART_TXD <= tx_buf_q[tx_idx_q][tx_bit_q];
          if (tx_cnt_q == 10'(BAUD_CYCLES - 1)) begin
            tx_cnt_q <= 10'h000;
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == 3'h7) begin
              tx_state_q <= MDSR_TX_STOP;
            end
          end else begin
            tx_cnt_q <= tx_cnt_q + 10'h001;
          end
        end
        MDSR_TX_STOP: begin
          UART_TXD <= 1'b1;
          if (tx_cnt_q == 10'(BAUD_CYCLES - 1)) begin
            tx_cnt_q <= 10'h000;
            if (tx_idx_q == 3'(REPLY_BYTES - 1)) begin
              tx_state_q <= MDSR_TX_IDLE;
            end else begin
              tx_idx_q <= tx_idx_q + 3'h1;
              tx_state_q <= MDSR_TX_START;
            end
          end else begin
            tx_cnt_q <= tx_cnt_q + 10'h001;
          end
        end
      endcase
    end
  end

endmodule

/* File: verification/mdsr_regbank_asserts.sv */
// Purpose: Port-level checks for the motor drive serial register bank.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Internal registers are hidden, so outputs are bounded by their inputs.
`timescale 1ns/1ps
module mdsr_regbank_asserts
  import mdsr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic UART_RXD,
  input wire logic UART_TXD,
  input wire logic [11:0] SPEED_ADC,
  input wire logic [11:0] LOAD_CURRENT,
  input wire logic [11:0] SERIAL_SPEED,
  input wire logic [13:0] FLASH_SAVED_MASK,
  input wire logic [11:0] OUTPUT_VOLTAGE,
  input wire logic [3:0] EFFECTIVE_LOCK,
  input wire logic [13:0] SAVE_SELECT,
  input wire logic [11:0] SCALE_LOW,
  input wire logic [11:0] SCALE_HIGH
);
  logic [11:0] demand_w;
  logic [3:0] saved_lk_w;
  assign demand_w = EFFECTIVE_LOCK[LK_SPEED] ? SERIAL_SPEED : SPEED_ADC;
  assign saved_lk_w = {FLASH_SAVED_MASK[SV_ACCEL], FLASH_SAVED_MASK[SV_REGEN],
                       FLASH_SAVED_MASK[SV_CURRENT], FLASH_SAVED_MASK[SV_SPEED]};

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  ////////////////////////////////////////////////////////////////////////////////
  property p_reset_values;
    $fell(SYS_RST) |-> SCALE_LOW == 12'h000 && SCALE_HIGH == 12'hFFF && SAVE_SELECT == 14'h0000;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("register reset values");
  property p_lock_cleared;
    $fell(SYS_RST) |-> EFFECTIVE_LOCK == 4'h0;
  endproperty
  a_lock_cleared: assert property (p_lock_cleared) else $error("lock mask not cleared");
  property p_tx_idle;
    $fell(SYS_RST) |-> UART_TXD [*8];
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("serial output not idle");
  property p_saved_lock;
    1'b1 |=> (EFFECTIVE_LOCK & $past(saved_lk_w)) == $past(saved_lk_w);
  endproperty
  a_saved_lock: assert property (p_saved_lock) else $error("saved value not locked");
  property p_save_undef;
    SAVE_SELECT[1] == 1'b0 && SAVE_SELECT[10] == 1'b0;
  endproperty
  a_save_undef: assert property (p_save_undef) else $error("undefined save bit set");
  // Writes land in the stop bit, so the line has been high for a while
  property p_write_on_stop;
    $changed(SAVE_SELECT) || $changed(SCALE_LOW) || $changed(SCALE_HIGH)
      |-> $past(UART_RXD, 2) && $past(UART_RXD, 8);
  endproperty
  a_write_on_stop: assert property (p_write_on_stop) else $error("write outside frame");
  property p_lock_serial;
    $changed(EFFECTIVE_LOCK) && $past(saved_lk_w) == $past(saved_lk_w, 2) |-> $past(UART_RXD, 2);
  endproperty
  a_lock_serial: assert property (p_lock_serial) else $error("lock changed without write");
  property p_out_bound;
    (LOAD_CURRENT == 12'h000) ##1 $stable(EFFECTIVE_LOCK) |-> OUTPUT_VOLTAGE <= $past(demand_w);
  endproperty
  a_out_bound: assert property (p_out_bound) else $error("output above demand");
endmodule

bind mdsr_regbank mdsr_regbank_asserts u_chk (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .UART_RXD(UART_RXD), .UART_TXD(UART_TXD),
  .SPEED_ADC(SPEED_ADC), .LOAD_CURRENT(LOAD_CURRENT), .SERIAL_SPEED(SERIAL_SPEED),
  .FLASH_SAVED_MASK(FLASH_SAVED_MASK), .OUTPUT_VOLTAGE(OUTPUT_VOLTAGE),
  .EFFECTIVE_LOCK(EFFECTIVE_LOCK), .SAVE_SELECT(SAVE_SELECT), .SCALE_LOW(SCALE_LOW),
  .SCALE_HIGH(SCALE_HIGH)
);

/* File: verification/mdsr_host_model.sv */
// Purpose: Host side of the serial command link, 8N1 frames.
// Assumes: 521 clock cycles per bit, line idles high.
// Notes: Never saves or restarts the device, so scaling is only stored.
`timescale 1ns/1ps
module mdsr_host_model
  import mdsr_pkg::*;
(
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  localparam int BIT_CLKS = 521;
  initial rxd = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1 rxd = (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i - 1]);
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask

  // Address with top bit, command, high and low 7-bit halves, 7-bit sum
  task automatic send_frame(input logic [6:0] addr, input logic [6:0] cmd, input logic [13:0] v);
    send_byte(ADDR_FLAG | {1'b0, addr});
    send_byte({1'b0, cmd});
    send_byte({1'b0, v[13:7]});
    send_byte({1'b0, v[6:0]});
    send_byte({1'b0, (cmd + v[13:7] + v[6:0]) & DATA7_MASK});
  endtask

  // Sampled on the falling edge so the registered line has settled
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (txd && n < 60000) begin
      @(negedge clk);
      n++;
    end
    ok = !txd;
    repeat (BIT_CLKS / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(negedge clk);
      b[i] = txd;
    end
    repeat (BIT_CLKS) @(negedge clk);
    ok = ok && txd;
  endtask
endmodule

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the motor drive serial register bank.
// Assumes: 10 MHz clock, frames of 26050 cycles, so only a few frames fit.
// Notes: A status read overlaps a lock write to save run time.
`timescale 1ns/1ps
module testbench;
  import mdsr_pkg::*;
  logic clk_sys, sys_rst, uart_rxd, uart_txd, pwm_brake_in, pwm_input_mode;
  logic reverse_active, forward_active, braking, over_temperature;
  logic [6:0] unit_addr;
  logic [11:0] speed_adc, load_current, serial_speed, supply_voltage, turn_on_min, turn_off_max;
  logic [15:0] config_two;
  logic [13:0] flash_saved_mask, save_select;
  logic [11:0] output_voltage, scale_low, scale_high;
  logic [3:0] effective_lock;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  mdsr_regbank #(.PULSE_TICK_DIV(2)) u_dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .UART_RXD(uart_rxd), .UART_TXD(uart_txd),
    .UNIT_ADDR(unit_addr), .SPEED_ADC(speed_adc), .LOAD_CURRENT(load_current),
    .SERIAL_SPEED(serial_speed), .SUPPLY_VOLTAGE(supply_voltage), .TURN_ON_MIN(turn_on_min),
    .TURN_OFF_MAX(turn_off_max), .PWM_BRAKE_IN(pwm_brake_in), .PWM_INPUT_MODE(pwm_input_mode),
    .REVERSE_ACTIVE(reverse_active), .FORWARD_ACTIVE(forward_active), .BRAKING(braking),
    .OVER_TEMPERATURE(over_temperature), .CONFIG_TWO(config_two),
    .FLASH_SAVED_MASK(flash_saved_mask), .OUTPUT_VOLTAGE(output_voltage),
    .EFFECTIVE_LOCK(effective_lock), .SAVE_SELECT(save_select), .SCALE_LOW(scale_low),
    .SCALE_HIGH(scale_high)
  );
  mdsr_host_model u_host (.clk(clk_sys), .txd(uart_txd), .rxd(uart_rxd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    tick(2);
    chk("scale_low", 16'h0000, {4'h0, scale_low});
    chk("scale_high", 16'h0FFF, {4'h0, scale_high});
    chk("save_select", 16'h0000, {2'h0, save_select});
    chk("lock", 16'h0000, {12'h000, effective_lock});
    chk("txd", 16'h0001, {15'h0000, uart_txd});
    chk("output", {4'h0, speed_adc}, {4'h0, output_voltage});
  endtask

  // Undefined bits 1 and 10 must stay clear
  task automatic t_save_mask();
    u_host.send_frame(unit_addr, WR_SAVE_ONE, 14'h3FFF);
    tick(4);
    chk("save_select", 16'h3BFD, {2'h0, save_select});
  endtask

  task automatic t_status_and_lock();
    logic [7:0] got [5];
    logic [7:0] exp_b [5];
    logic ok [5];
    logic [13:0] exp_st;
    // Reverse, pin high, braking, hot, supply below turn-on
    exp_st = 14'h0515;
    exp_b = '{{1'b1, unit_addr}, {1'b0, RD_STATUS}, {1'b0, exp_st[13:7]}, {1'b0, exp_st[6:0]},
              {1'b0, RD_STATUS + exp_st[13:7] + exp_st[6:0]}};
    fork
      begin
        u_host.send_frame(unit_addr, RD_STATUS, 14'h0000);
        u_host.send_frame(unit_addr, WR_LOCK, 14'h0005);
      end
      for (int i = 0; i < 5; i++) begin
        u_host.recv_byte(got[i], ok[i]);
      end
    join
    tick(4);
    for (int i = 0; i < 5; i++) begin
      chk("reply_framing", 16'h0001, {15'h0000, ok[i]});
      chk("reply_byte", {8'h00, exp_b[i]}, {8'h00, got[i]});
    end
    chk("lock", 16'h0005, {12'h000, effective_lock});
    chk("output", {4'h0, serial_speed}, {4'h0, output_voltage});
  endtask

  // Saved values lock; ceiling at its reset value scales or caps the demand
  task automatic t_saved_and_output();
    logic [23:0] prod;
    flash_saved_mask = 14'h0014;
    tick(2);
    chk("lock", 16'h000F, {12'h000, effective_lock});
    config_two = 16'h0100;
    prod = serial_speed * CEILING_RESET;
    tick(2);
    chk("output", {4'h0, prod[23:12]}, {4'h0, output_voltage});
    config_two = 16'h0000;
    load_current = 12'hFFF;
    tick(2);
    chk("output", {4'h0, serial_speed}, {4'h0, output_voltage});
  endtask

  // Restart as the host does after saving: serial locks drop, saved ones reload
  task automatic t_restart();
    sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    tick(2);
    chk("lock", 16'h000A, {12'h000, effective_lock});
    chk("save_select", 16'h0000, {2'h0, save_select});
    chk("output", {4'h0, speed_adc}, {4'h0, output_voltage});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Three frames plus an overlapped reply take about 78200 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    sys_rst = 1'b1;
    unit_addr = 7'h05;
    speed_adc = 12'h123;
    load_current = 12'h000;
    serial_speed = 12'h800;
    supply_voltage = 12'h100;
    turn_on_min = 12'h200;
    turn_off_max = 12'hFFF;
    pwm_brake_in = 1'b1;
    pwm_input_mode = 1'b0;
    reverse_active = 1'b1;
    forward_active = 1'b0;
    braking = 1'b1;
    over_temperature = 1'b1;
    config_two = 16'h0000;
    flash_saved_mask = 14'h0000;
    tick(10);
    sys_rst = 1'b0;
    t_reset_values();
    t_save_mask();
    t_status_and_lock();
    t_saved_and_output();
    t_restart();
    report_and_stop();
  end
endmodule
